/* rtl/ast_cfg.svh */
// Constants of the async serial port: register indices, field bits,
// reset values and bit timing. Included by the package and the core.
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
// ==========================================
// Register indices (3-bit address)
`define AST_ADR_TXSC 3'h0
`define AST_ADR_RXSC 3'h1
`define AST_ADR_BAUD 3'h2
`define AST_ADR_HOLD 3'h3
`define AST_ADR_RXD 3'h4
`define AST_ADR_FLAGS 3'h5
`define AST_ADR_IEN 3'h6
`define AST_ADR_IRQC 3'h7
// ==========================================
// tx_status_control fields
`define AST_TX9 6
`define AST_TX_ENABLE_BIT 5
`define AST_SYNC 4
`define AST_BAUD_HIGH_SPEED 2
`define AST_SHIFTER_EMPTY 1
`define AST_TX_NINTH_BIT 0
`define AST_TXSC_WMASK 8'hF5
`define AST_TXSC_RST 8'h00
// rx_status_control fields, then the baud register reset value
`define AST_SERIAL_PORT_ENABLE 7
`define AST_RX9 6
`define AST_RX_CONTINUOUS_ENABLE 4
`define AST_ADDEN 3
`define AST_FRAME_ERROR_FLAG 2
`define AST_OVERRUN_FLAG 1
`define AST_RX9D 0
`define AST_RXSC_WMASK 8'hF8
`define AST_RXSC_RST 8'h00
`define AST_BAUD_RST 8'h00
// Flag, enable and global control fields
`define AST_RCB 5
`define AST_TXB 4
`define AST_GIE 7
`define AST_PERIPH_IRQ_ENABLE 6
// ==========================================
// Bit timing in oversample ticks, last data bit indices and FIFO full count
`define AST_TICK_LAST 4'hF
`define AST_HALF_LAST 4'h7
`define AST_VOTE_A 4'hD
`define AST_VOTE_B 4'hE
`define AST_LAST_BIT8 4'h7
`define AST_LAST_BIT9 4'h8
`define AST_FIFO_FULL 2'h2
`endif

/* rtl/ast_pkg.sv */
// Types of the async serial port.
// Assumes ast_cfg.svh on the include path.
`include "ast_cfg.svh"
package ast_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ast_bus_req_type;
  typedef struct packed {
    logic frame_error_flag;
    logic [8:0] data;
  } ast_rx_entry_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_type;
endpackage

/* rtl/ast_serial.sv */
// Async serial port core: transmitter, receiver, register file.
// Assumes a 16x baud tick from an outside generator and a bus master
// that gives one-cycle read and write strobes.
`timescale 1ns/100ps
`default_nettype none
`include "ast_cfg.svh"
module ast_serial
  import ast_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire ast_pkg::ast_bus_req_type bus_req,
  output logic [7:0] rdata,
  // Baud generator link
  input wire logic baud_tick,
  output logic [7:0] baud_divisor_o,
  output logic baud_high_speed_o,
  // Receive pin
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe,
  // Transmit pin
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  // Port latch and direction, bit 0 receive pin, bit 1 transmit pin
  input wire logic [1:0] port_latch,
  input wire logic [1:0] pin_direction,
  // Interrupt request
  output logic irq_o
);
  import ast_pkg::*;

  // Majority of three samples
  function automatic logic ast_major(input logic a, input logic b, input logic c);
    ast_major = (a & b) | (a & c) | (b & c);
  endfunction

  // ==========================================
  // Register file
  logic [7:0] txsc_ff, nxt_txsc_ff, rxsc_ff, nxt_rxsc_ff, baud_ff, nxt_baud_ff;
  logic [7:0] ien_ff, nxt_ien_ff, irqc_ff, nxt_irqc_ff, rdata_ff, nxt_rdata_ff;
  logic irq_ff, nxt_irq_ff, tx_buffer_free_flag_ff, nxt_tx_buffer_free_flag_ff, hold_full_ff, nxt_hold_full_ff;
  logic serial_port_enable, tx_run, rx_run, wr_hold, pop, rx_data_avail_flag, shifter_empty;
  logic [1:0] cnt_ff;
  logic overrun_flag_ff;
  ast_rx_entry_type head;
  logic rd_ptr_ff;
  ast_rx_entry_type fifo_ff [2];
  ast_tx_state_type tx_state_ff;

  assign serial_port_enable = rxsc_ff[`AST_SERIAL_PORT_ENABLE];
  assign tx_run = serial_port_enable & txsc_ff[`AST_TX_ENABLE_BIT] & ~txsc_ff[`AST_SYNC];
  assign wr_hold = bus_req.wr && (bus_req.addr == `AST_ADR_HOLD);
  assign pop = bus_req.rd && (bus_req.addr == `AST_ADR_RXD) && (cnt_ff != 2'h0);
  assign head = fifo_ff[rd_ptr_ff];
  assign rx_data_avail_flag = serial_port_enable && (cnt_ff != 2'h0);
  assign shifter_empty = (tx_state_ff == TX_IDLE);

  // Control writes, read mux, gated request
  always_comb
  begin
    nxt_txsc_ff = txsc_ff;
    nxt_rxsc_ff = rxsc_ff;
    nxt_baud_ff = baud_ff;
    nxt_ien_ff = ien_ff;
    nxt_irqc_ff = irqc_ff;
    nxt_rdata_ff = 8'h00;
    if (bus_req.wr)
    begin
      // Flags register absent here: its bits cannot be written
      case (bus_req.addr)
        `AST_ADR_TXSC: nxt_txsc_ff = bus_req.wdata & `AST_TXSC_WMASK;
        `AST_ADR_RXSC: nxt_rxsc_ff = bus_req.wdata & `AST_RXSC_WMASK;
        `AST_ADR_BAUD: nxt_baud_ff = bus_req.wdata;
        `AST_ADR_IEN: nxt_ien_ff = bus_req.wdata & 8'h30;
        `AST_ADR_IRQC: nxt_irqc_ff = bus_req.wdata & 8'hC0;
        default: nxt_baud_ff = baud_ff;
      endcase
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `AST_ADR_TXSC: nxt_rdata_ff = txsc_ff | {6'h00, shifter_empty, 1'b0};
        `AST_ADR_RXSC: nxt_rdata_ff = rxsc_ff | {5'h00, head.frame_error_flag & rx_data_avail_flag, overrun_flag_ff,
                                                  head.data[8] & rx_data_avail_flag};
        `AST_ADR_BAUD: nxt_rdata_ff = baud_ff;
        `AST_ADR_RXD: nxt_rdata_ff = rx_data_avail_flag ? head.data[7:0] : 8'h00;
        `AST_ADR_FLAGS: nxt_rdata_ff = {2'h0, rx_data_avail_flag, tx_buffer_free_flag_ff, 4'h0};
        `AST_ADR_IEN: nxt_rdata_ff = ien_ff;
        `AST_ADR_IRQC: nxt_rdata_ff = irqc_ff;
        default: nxt_rdata_ff = 8'h00;
      endcase
    end
    // Flag lags the holding state one cycle
    nxt_tx_buffer_free_flag_ff = tx_run && !(hold_full_ff);
    // Shifter-empty deliberately left out of the request
    nxt_irq_ff = irqc_ff[`AST_GIE] && irqc_ff[`AST_PERIPH_IRQ_ENABLE] &&
                 ((tx_buffer_free_flag_ff && ien_ff[`AST_TXB]) || (rx_data_avail_flag && ien_ff[`AST_RCB]));
  end

  // Register file flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txsc_ff <= `AST_TXSC_RST;
      rxsc_ff <= `AST_RXSC_RST;
      baud_ff <= `AST_BAUD_RST;
      ien_ff <= 8'h00;
      irqc_ff <= 8'h00;
      rdata_ff <= 8'h00;
      tx_buffer_free_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      txsc_ff <= nxt_txsc_ff;
      rxsc_ff <= nxt_rxsc_ff;
      baud_ff <= nxt_baud_ff;
      ien_ff <= nxt_ien_ff;
      irqc_ff <= nxt_irqc_ff;
      rdata_ff <= nxt_rdata_ff;
      tx_buffer_free_flag_ff <= nxt_tx_buffer_free_flag_ff;
      irq_ff <= nxt_irq_ff;
    end
  end

  // ==========================================
  // Transmitter
  logic tx_n9_ff, nxt_tx_n9_ff, tx_load, tx_bit_end;
  logic [8:0] hold_ff, nxt_hold_ff, tx_shift_ff, nxt_tx_shift_ff;
  logic [3:0] tx_tick_ff, nxt_tx_tick_ff, tx_bit_ff, nxt_tx_bit_ff;
  ast_tx_state_type nxt_tx_state_ff;

  assign tx_bit_end = baud_tick && (tx_tick_ff == `AST_TICK_LAST);
  // Load when idle, or straight out of the stop bit
  assign tx_load = tx_run && hold_full_ff &&
                   (tx_state_ff == TX_IDLE || (tx_state_ff == TX_STOP && tx_bit_end));

  // Holding register and shifter sequencing
  always_comb
  begin
    nxt_hold_ff = hold_ff;
    nxt_hold_full_ff = (hold_full_ff && !tx_load) || wr_hold;
    nxt_tx_state_ff = tx_state_ff;
    nxt_tx_tick_ff = baud_tick ? tx_tick_ff + 4'h1 : tx_tick_ff;
    nxt_tx_bit_ff = tx_bit_ff;
    nxt_tx_shift_ff = tx_shift_ff;
    nxt_tx_n9_ff = tx_n9_ff;
    if (wr_hold)
      nxt_hold_ff = {txsc_ff[`AST_TX_NINTH_BIT], bus_req.wdata};
    case (tx_state_ff)
      TX_IDLE: nxt_tx_tick_ff = 4'h0;
      TX_START:
        if (tx_bit_end)
        begin
          nxt_tx_state_ff = TX_DATA;
          nxt_tx_bit_ff = 4'h0;
        end
      TX_DATA:
        if (tx_bit_end)
        begin
          nxt_tx_shift_ff = {1'b0, tx_shift_ff[8:1]};
          nxt_tx_bit_ff = tx_bit_ff + 4'h1;
          if (tx_bit_ff == (tx_n9_ff ? `AST_LAST_BIT9 : `AST_LAST_BIT8))
            nxt_tx_state_ff = TX_STOP;
        end
      TX_STOP:
        if (tx_bit_end)
          nxt_tx_state_ff = TX_IDLE;
      default: nxt_tx_state_ff = TX_IDLE;
    endcase
    if (tx_load)
    begin
      nxt_tx_state_ff = TX_START;
      nxt_tx_tick_ff = 4'h0;
      nxt_tx_shift_ff = hold_ff;
      nxt_tx_n9_ff = txsc_ff[`AST_TX9];
    end
    if (!tx_run)
    begin
      nxt_tx_state_ff = TX_IDLE;
      nxt_hold_full_ff = 1'b0;
    end
  end

  // Transmitter flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_ff <= 9'h000;
      hold_full_ff <= 1'b0;
      tx_state_ff <= TX_IDLE;
      tx_tick_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_shift_ff <= 9'h000;
      tx_n9_ff <= 1'b0;
    end
    else
    begin
      hold_ff <= nxt_hold_ff;
      hold_full_ff <= nxt_hold_full_ff;
      tx_state_ff <= nxt_tx_state_ff;
      tx_tick_ff <= nxt_tx_tick_ff;
      tx_bit_ff <= nxt_tx_bit_ff;
      tx_shift_ff <= nxt_tx_shift_ff;
      tx_n9_ff <= nxt_tx_n9_ff;
    end
  end

  // ==========================================
  // Receiver and two-entry FIFO
  logic sync1_ff, sync2_ff, sync3_ff, line_ff, nxt_line_ff, prev_ff, vote_end;
  logic rx_n9_ff, nxt_rx_n9_ff, nxt_overrun_flag_ff, nxt_rd_ptr_ff, push, smp;
  logic [1:0] vote_ff, nxt_vote_ff, nxt_cnt_ff;
  logic [3:0] rx_tick_ff, nxt_rx_tick_ff, rx_bit_ff, nxt_rx_bit_ff;
  logic [8:0] rx_shift_ff, nxt_rx_shift_ff;
  ast_rx_state_type rx_state_ff, nxt_rx_state_ff;
  ast_rx_entry_type fifo_in;
  ast_rx_entry_type nxt_fifo_ff [2];

  assign rx_run = serial_port_enable & rxsc_ff[`AST_RX_CONTINUOUS_ENABLE] & ~txsc_ff[`AST_SYNC] & ~overrun_flag_ff;
  assign vote_end = baud_tick && (rx_tick_ff == `AST_TICK_LAST);
  assign smp = ast_major(vote_ff[0], vote_ff[1], line_ff);

  // Recovery state machine, FIFO and overrun
  always_comb
  begin
    nxt_line_ff = (sync2_ff == sync3_ff) ? sync3_ff : line_ff;
    nxt_rx_state_ff = rx_state_ff;
    nxt_rx_tick_ff = baud_tick ? rx_tick_ff + 4'h1 : rx_tick_ff;
    nxt_rx_bit_ff = rx_bit_ff;
    nxt_rx_shift_ff = rx_shift_ff;
    nxt_rx_n9_ff = rx_n9_ff;
    nxt_vote_ff = vote_ff;
    nxt_overrun_flag_ff = overrun_flag_ff;
    nxt_fifo_ff = fifo_ff;
    push = 1'b0;
    fifo_in.frame_error_flag = ~smp;
    fifo_in.data = rx_n9_ff ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
    if (baud_tick && rx_tick_ff == `AST_VOTE_A)
      nxt_vote_ff[0] = line_ff;
    if (baud_tick && rx_tick_ff == `AST_VOTE_B)
      nxt_vote_ff[1] = line_ff;
    case (rx_state_ff)
      RX_IDLE:
        begin
          nxt_rx_tick_ff = 4'h0;
          if (prev_ff && !line_ff)
            nxt_rx_state_ff = RX_START;
        end
      RX_START:
        if (baud_tick && rx_tick_ff == `AST_HALF_LAST)
        begin
          // Half bit on: still low or silently drop
          nxt_rx_tick_ff = 4'h0;
          nxt_rx_bit_ff = 4'h0;
          nxt_rx_n9_ff = rxsc_ff[`AST_RX9];
          nxt_rx_state_ff = line_ff ? RX_IDLE : RX_DATA;
        end
      RX_DATA:
        if (vote_end)
        begin
          nxt_rx_shift_ff = {smp, rx_shift_ff[8:1]};
          nxt_rx_bit_ff = rx_bit_ff + 4'h1;
          if (rx_bit_ff == (rx_n9_ff ? `AST_LAST_BIT9 : `AST_LAST_BIT8))
            nxt_rx_state_ff = RX_STOP;
        end
      RX_STOP:
        if (vote_end)
        begin
          nxt_rx_state_ff = RX_IDLE;
          // Address mode drops characters with a clear ninth bit
          if (!(rxsc_ff[`AST_ADDEN] && rx_n9_ff && !fifo_in.data[8]))
          begin
            if (cnt_ff == `AST_FIFO_FULL && !pop)
              nxt_overrun_flag_ff = 1'b1;
            else
              push = 1'b1;
          end
        end
      default: nxt_rx_state_ff = RX_IDLE;
    endcase
    if (!rx_run)
      nxt_rx_state_ff = RX_IDLE;
    if (push)
      nxt_fifo_ff[rd_ptr_ff ^ cnt_ff[0]] = fifo_in;
    nxt_cnt_ff = cnt_ff + {1'b0, push} - {1'b0, pop};
    nxt_rd_ptr_ff = rd_ptr_ff ^ pop;
    if (!rxsc_ff[`AST_RX_CONTINUOUS_ENABLE])
      nxt_overrun_flag_ff = 1'b0;
    if (!serial_port_enable)
    begin
      // Port disable resets the receive side
      nxt_overrun_flag_ff = 1'b0;
      nxt_cnt_ff = 2'h0;
      nxt_rd_ptr_ff = 1'b0;
    end
  end

  // Receiver flops, pin input through three stages
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      line_ff <= 1'b1;
      prev_ff <= 1'b1;
      rx_state_ff <= RX_IDLE;
      rx_tick_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_shift_ff <= 9'h000;
      rx_n9_ff <= 1'b0;
      vote_ff <= 2'h3;
      overrun_flag_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rd_ptr_ff <= 1'b0;
      fifo_ff[0] <= '0;
      fifo_ff[1] <= '0;
    end
    else
    begin
      sync1_ff <= rx_pin_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      line_ff <= nxt_line_ff;
      prev_ff <= line_ff;
      rx_state_ff <= nxt_rx_state_ff;
      rx_tick_ff <= nxt_rx_tick_ff;
      rx_bit_ff <= nxt_rx_bit_ff;
      rx_shift_ff <= nxt_rx_shift_ff;
      rx_n9_ff <= nxt_rx_n9_ff;
      vote_ff <= nxt_vote_ff;
      overrun_flag_ff <= nxt_overrun_flag_ff;
      cnt_ff <= nxt_cnt_ff;
      rd_ptr_ff <= nxt_rd_ptr_ff;
      fifo_ff <= nxt_fifo_ff;
    end
  end

  // ==========================================
  // Outputs and pin steering
  logic tx_serial;
  assign tx_serial = (tx_state_ff == TX_START) ? 1'b0 :
                     (tx_state_ff == TX_DATA) ? tx_shift_ff[0] : 1'b1;
  assign tx_pin_o = serial_port_enable ? tx_serial : port_latch[1];
  assign tx_pin_oe = serial_port_enable | ~pin_direction[1];
  assign rx_pin_o = port_latch[0];
  assign rx_pin_oe = ~serial_port_enable & ~pin_direction[0];
  assign rdata = rdata_ff;
  assign irq_o = irq_ff;
  assign baud_divisor_o = baud_ff;
  assign baud_high_speed_o = txsc_ff[`AST_BAUD_HIGH_SPEED];

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_tx_buffer_free_flag_free: assert property ((tx_run && !hold_full_ff)[*2] |-> tx_buffer_free_flag_ff)
    else $error("buffer-free flag low with empty holding register");
  chk_tx_buffer_free_flag_lag: assert property (wr_hold && tx_run && !shifter_empty && !tx_bit_end
                                 |-> ##2 !tx_buffer_free_flag_ff)
    else $error("buffer-free flag not low two cycles after queued write");
  chk_irq_gate: assert property (irq_o |-> $past(irqc_ff[`AST_GIE] && irqc_ff[`AST_PERIPH_IRQ_ENABLE]))
    else $error("request raised without global enables");
  chk_no_shifter_empty_irq: assert property (irq_o |-> $past(tx_buffer_free_flag_ff || rx_data_avail_flag))
    else $error("request without a flag");
  chk_load_busy: assert property (tx_load |=> !shifter_empty ##0 tx_pin_o == 1'b0)
    else $error("load did not start a start bit");
  chk_ninth_bit: assert property (tx_load && txsc_ff[`AST_TX9] |=> tx_n9_ff
                                  && tx_shift_ff == $past(hold_ff))
    else $error("nine bits not moved together");
  chk_rx_gate: assert property (rx_state_ff != RX_IDLE |-> $past(rx_run))
    else $error("receiver active while disabled");
  chk_pin_dir: assert property (serial_port_enable |-> tx_pin_oe && !rx_pin_oe)
    else $error("pin direction not overridden");
  chk_pop_one: assert property (pop && cnt_ff == 2'h1 && !push && serial_port_enable |=> cnt_ff == 2'h0)
    else $error("read did not remove character");
  chk_overrun_hold: assert property (overrun_flag_ff |-> rx_state_ff == RX_IDLE
                                     && !push)
    else $error("receiver accepted during overrun");
  chk_serial_port_enable_clear: assert property (!serial_port_enable |=> cnt_ff == 2'h0 && !overrun_flag_ff)
    else $error("port disable did not clear receive side");
endmodule // ast_serial
`default_nettype wire

/* verif/ast_remote.sv */
// Far-end partner: a remote asynchronous transmitter and receiver.
// Assumes the same clock and oversample tick as the serial port.
`timescale 1ns/100ps
`default_nettype none
module ast_remote
(
  // Clock and shared oversample tick
  input wire logic clk,
  input wire logic baud_tick,
  // Serial lines and character length
  input wire logic line_in,
  input wire logic nine,
  output logic line_out
);
  logic [9:0] got_q[$];
  // Line idles high between frames
  initial line_out = 1'b1;
  // Counts oversample ticks, 16 per bit
  task automatic ticks(input int n);
    int i;
    i = 0;
    while (i < n)
    begin
      @(posedge clk);
      if (baud_tick) i++;
    end
  endtask
  // Low start, data LSB first, stop high unless told otherwise
  task automatic send(input logic [8:0] d, input logic stop_ok);
    line_out <= 1'b0;
    ticks(16);
    for (int k = 0; k < (nine ? 9 : 8); k++)
    begin
      line_out <= d[k];
      ticks(16);
    end
    line_out <= stop_ok;
    ticks(16);
    line_out <= 1'b1;
    ticks(2);
  endtask
  // Short low pulse that is no start bit
  task automatic glitch();
    line_out <= 1'b0;
    ticks(4);
    line_out <= 1'b1;
    ticks(40);
  endtask
  // Frames each character seen on the line, stop level on top
  initial
  begin
    logic [8:0] v;
    forever
    begin
      @(posedge clk);
      if (line_in === 1'b0)
      begin
        ticks(8);
        v = '0;
        for (int k = 0; k < (nine ? 9 : 8); k++)
        begin
          ticks(16);
          v[k] = line_in;
        end
        ticks(16);
        got_q.push_back({line_in, v});
      end
    end
  end
endmodule // ast_remote
`default_nettype wire

/* verif/ast_serial_bench.sv */
// Bench for the async serial port: bus tasks and one task per scenario.
// Assumes ast_remote as far end and an oversample tick every 4 clocks.
`include "ast_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ast_serial_bench;
  import ast_pkg::*;
  logic clk, arst_n, baud_tick, baud_hs, rx_o, rx_oe, tx_o, tx_oe, irq;
  logic rem_line, rx_wire, tx_wire, nine;
  ast_bus_req_type bus_req;
  logic [7:0] rdata, baud_div;
  logic [1:0] tick_cnt, pin_direction, port_latch;
  int fail_count = 0;
  int n_tests = 0;
  // Pin levels from all drivers; transmit line pulled up
  assign rx_wire = rx_oe ? rx_o : rem_line;
  assign tx_wire = tx_oe ? tx_o : 1'b1;
  ast_serial dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .baud_tick(baud_tick), .baud_divisor_o(baud_div), .baud_high_speed_o(baud_hs),
    .rx_pin_i(rx_wire), .rx_pin_o(rx_o), .rx_pin_oe(rx_oe), .tx_pin_i(tx_wire),
    .tx_pin_o(tx_o), .tx_pin_oe(tx_oe), .port_latch(port_latch),
    .pin_direction(pin_direction), .irq_o(irq));
  ast_remote rem (.clk(clk), .baud_tick(baud_tick), .line_in(tx_wire), .nine(nine),
    .line_out(rem_line));
  // ==========================================
  // Clock and oversample tick
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    baud_tick <= (tick_cnt == 2'h3);
  end
  // ==========================================
  // Verdict and comparison
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register bus: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    // Read data stand only in the cycle after the strobe
    #1 v = rdata;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk({2'b00, v}, {2'b00, e});
  endtask
  // Bounded wait for characters at the far end
  task automatic wait_q(input int n);
    int c;
    c = 0;
    while (rem.got_q.size() < n)
    begin
      @(posedge clk);
      c++;
      if (c > 20000)
      begin
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, rem.got_q.size(), n);
        stop_test();
      end
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] e [8] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int a = 0; a < 8; a++)
      rc(3'(a), e[a]);
    chk(10'(tx_oe), 10'h0);
    wr(`AST_ADR_BAUD, 8'h5A);
    rc(`AST_ADR_BAUD, 8'h5A);
    chk(10'(baud_div), 10'h05A);
    $display("test reset done");
  endtask
  task automatic t_enable();
    pin_direction <= 2'b00;
    wr(`AST_ADR_RXSC, 8'h80);
    wr(`AST_ADR_TXSC, 8'h24);
    rc(`AST_ADR_FLAGS, 8'h10);
    chk(10'({rx_oe, tx_oe, baud_hs, irq}), 10'h006);
    // Port latch must not reach the transmit pin while the port is on
    port_latch <= 2'b00;
    #2 chk(10'({tx_o, rx_o}), 10'h002);
    port_latch <= 2'b11;
    wr(`AST_ADR_FLAGS, 8'h00);
    rc(`AST_ADR_FLAGS, 8'h10);
    wr(`AST_ADR_IEN, 8'h10);
    wr(`AST_ADR_IRQC, 8'hC0);
    rc(`AST_ADR_IEN, 8'h10);
    chk(10'(irq), 10'h1);
    wr(`AST_ADR_IRQC, 8'h40);
    rc(`AST_ADR_IRQC, 8'h40);
    chk(10'(irq), 10'h0);
    wr(`AST_ADR_IEN, 8'h00);
    wr(`AST_ADR_IRQC, 8'hC0);
    rc(`AST_ADR_FLAGS, 8'h10);
    chk(10'(irq), 10'h0);
    wr(`AST_ADR_IRQC, 8'h00);
    $display("test enable done");
  endtask
  task automatic t_tx();
    wr(`AST_ADR_HOLD, 8'hA5);
    wr(`AST_ADR_HOLD, 8'h3C);
    rc(`AST_ADR_FLAGS, 8'h00);
    rc(`AST_ADR_TXSC, 8'h24);
    wait_q(2);
    chk(rem.got_q[0], 10'h2A5);
    chk(rem.got_q[1], 10'h23C);
    repeat (40) @(posedge clk);
    rc(`AST_ADR_TXSC, 8'h26);
    chk(10'(tx_o), 10'h1);
    rem.got_q.delete();
    nine = 1'b1;
    wr(`AST_ADR_TXSC, 8'h65);
    wr(`AST_ADR_HOLD, 8'h55);
    wr(`AST_ADR_TXSC, 8'h64);
    wait_q(1);
    chk(rem.got_q[0], 10'h355);
    repeat (40) @(posedge clk);
    rem.got_q.delete();
    nine = 1'b0;
    wr(`AST_ADR_TXSC, 8'h24);
    $display("test transmit done");
  endtask
  task automatic t_rx();
    rem.send(9'h0C3, 1'b1);
    rc(`AST_ADR_FLAGS, 8'h10);
    wr(`AST_ADR_RXSC, 8'h90);
    rem.glitch();
    rc(`AST_ADR_FLAGS, 8'h10);
    rem.send(9'h04B, 1'b1);
    rc(`AST_ADR_FLAGS, 8'h30);
    rc(`AST_ADR_RXSC, 8'h90);
    rc(`AST_ADR_RXD, 8'h4B);
    rc(`AST_ADR_FLAGS, 8'h10);
    rem.send(9'h0F0, 1'b0);
    rc(`AST_ADR_RXSC, 8'h94);
    rc(`AST_ADR_RXD, 8'hF0);
    rem.send(9'h011, 1'b0);
    wr(`AST_ADR_RXSC, 8'h10);
    rc(`AST_ADR_RXSC, 8'h10);
    wr(`AST_ADR_RXSC, 8'h90);
    rc(`AST_ADR_RXD, 8'h00);
    rc(`AST_ADR_RXD, 8'h00);
    // Nine-bit reception, then address mode dropping a clear ninth bit
    nine <= 1'b1;
    wr(`AST_ADR_RXSC, 8'hD0);
    rem.send(9'h1A5, 1'b1);
    rc(`AST_ADR_RXSC, 8'hD1);
    rc(`AST_ADR_RXD, 8'hA5);
    wr(`AST_ADR_RXSC, 8'hD8);
    rem.send(9'h033, 1'b1);
    rem.send(9'h1C3, 1'b1);
    rc(`AST_ADR_RXSC, 8'hD9);
    rc(`AST_ADR_RXD, 8'hC3);
    rc(`AST_ADR_FLAGS, 8'h10);
    wr(`AST_ADR_RXSC, 8'h90);
    nine <= 1'b0;
    $display("test receive done");
  endtask
  task automatic t_overrun();
    rem.send(9'h001, 1'b1);
    rem.send(9'h002, 1'b1);
    rem.send(9'h003, 1'b1);
    rc(`AST_ADR_RXSC, 8'h92);
    rem.send(9'h004, 1'b1);
    rc(`AST_ADR_RXD, 8'h01);
    rc(`AST_ADR_RXD, 8'h02);
    rc(`AST_ADR_FLAGS, 8'h10);
    wr(`AST_ADR_RXSC, 8'h80);
    wr(`AST_ADR_RXSC, 8'h90);
    rc(`AST_ADR_RXSC, 8'h90);
    rem.send(9'h05A, 1'b1);
    rc(`AST_ADR_RXD, 8'h5A);
    $display("test overrun done");
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    bus_req = '0;
    arst_n = 1'b0;
    baud_tick = 1'b0;
    tick_cnt = 2'h0;
    pin_direction = 2'b11;
    port_latch = 2'b11;
    nine = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_enable();
    t_tx();
    t_rx();
    t_overrun();
    stop_test();
  end
endmodule // ast_serial_bench
`default_nettype wire
